/* core/cpudec_regs.vh */
`ifndef CPUDEC_REGS_VH
`define CPUDEC_REGS_VH

// register select codes inside 3-bit fields
`define CPUDEC_SEL_B      3'h0
`define CPUDEC_SEL_C      3'h1
`define CPUDEC_SEL_D      3'h2
`define CPUDEC_SEL_E      3'h3
`define CPUDEC_SEL_H      3'h4
`define CPUDEC_SEL_L      3'h5
`define CPUDEC_SEL_MEM    3'h6
`define CPUDEC_SEL_A      3'h7

// field positions in the opcode byte
`define CPUDEC_DST_MSB    5
`define CPUDEC_DST_LSB    3
`define CPUDEC_SRC_MSB    2
`define CPUDEC_SRC_LSB    0

// fixed opcodes
`define CPUDEC_OP_LDI_BC  8'h01
`define CPUDEC_OP_LDI_DE  8'h11
`define CPUDEC_OP_LDI_HL  8'h21
`define CPUDEC_OP_LDI_SP  8'h31
`define CPUDEC_OP_SWAP    8'he3
`define CPUDEC_OP_JHL     8'he9
`define CPUDEC_OP_HALT    8'h76

// operation class codes
`define CPUDEC_CLS_NONE   3'h0
`define CPUDEC_CLS_COPY   3'h1
`define CPUDEC_CLS_STORE  3'h2
`define CPUDEC_CLS_LOAD   3'h3
`define CPUDEC_CLS_LDPAIR 3'h4
`define CPUDEC_CLS_LDSP   3'h5
`define CPUDEC_CLS_SWAP   3'h6
`define CPUDEC_CLS_JHL    3'h7

// pair select codes
`define CPUDEC_PAIR_BC    2'h0
`define CPUDEC_PAIR_DE    2'h1
`define CPUDEC_PAIR_HL    2'h2
`define CPUDEC_PAIR_SP    2'h3

// immediate bytes that follow a 16-bit load opcode
`define CPUDEC_IMM_BYTES  2'h2

// reset values
`define CPUDEC_RST_CLASS  3'h0
`define CPUDEC_RST_SEL    3'h0

`endif

/* core/cpudec_cls.v */
`timescale 1ns/1ns
`include "cpudec_regs.vh"

// pure opcode classifier, no state
module cpudec_cls (
  // opcode in
  input  wire [7:0] opcode,
  // class out
  output reg  [2:0] op_class,
  output reg  [1:0] pair_sel,
  output reg        two_imm
);

  // fixed codes first so the 01110110 hole never reads as a store
  always @* begin
    op_class = `CPUDEC_CLS_NONE;
    pair_sel = `CPUDEC_PAIR_BC;
    two_imm  = 1'b0;
    case (opcode)
      `CPUDEC_OP_LDI_BC: begin
        op_class = `CPUDEC_CLS_LDPAIR;
        pair_sel = `CPUDEC_PAIR_BC;
        two_imm  = 1'b1;
      end
      `CPUDEC_OP_LDI_DE: begin
        op_class = `CPUDEC_CLS_LDPAIR;
        pair_sel = `CPUDEC_PAIR_DE;
        two_imm  = 1'b1;
      end
      `CPUDEC_OP_LDI_HL: begin
        op_class = `CPUDEC_CLS_LDPAIR;
        pair_sel = `CPUDEC_PAIR_HL;
        two_imm  = 1'b1;
      end
      `CPUDEC_OP_LDI_SP: begin
        op_class = `CPUDEC_CLS_LDSP;
        pair_sel = `CPUDEC_PAIR_SP;
        two_imm  = 1'b1;
      end
      `CPUDEC_OP_SWAP: begin
        op_class = `CPUDEC_CLS_SWAP;
        pair_sel = `CPUDEC_PAIR_HL;
      end
      `CPUDEC_OP_JHL: begin
        op_class = `CPUDEC_CLS_JHL;
        pair_sel = `CPUDEC_PAIR_HL;
      end
      `CPUDEC_OP_HALT: begin
        op_class = `CPUDEC_CLS_NONE; // code 110 in both fields is no move
      end
      default: begin
        if (opcode[7:6] == 2'h1) begin
          if (opcode[`CPUDEC_DST_MSB:`CPUDEC_DST_LSB] == `CPUDEC_SEL_MEM) begin
            op_class = `CPUDEC_CLS_STORE;
            pair_sel = `CPUDEC_PAIR_HL;
          end else if (opcode[`CPUDEC_SRC_MSB:`CPUDEC_SRC_LSB] == `CPUDEC_SEL_MEM) begin
            op_class = `CPUDEC_CLS_LOAD;
            pair_sel = `CPUDEC_PAIR_HL;
          end else begin
            op_class = `CPUDEC_CLS_COPY;
          end
        end
      end
    endcase
  end

endmodule

/* core/cpudec_top.v */
`timescale 1ns/1ns
`include "cpudec_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - 01DDDSSS copies source register SSS into destination register DDD.
// - 01110SSS stores source register SSS to memory addressed by HL.
// - 01DDD110 loads destination register DDD from memory addressed by HL.
// - 01, 11, 21 hex load BC, DE, HL with the next two bytes.
// - 31 hex loads the stack pointer with the next two bytes.
// - e3 hex swaps HL with stack top; stack pointer unchanged.
// - e9 hex loads the program counter from HL.
module cpudec_top (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  // byte stream from fetch
  input  wire [7:0] fetch_byte,
  input  wire       fetch_valid,
  output wire       fetch_ready,
  // decoded controls
  output reg        dec_valid,
  output reg  [2:0] op_class,
  output reg  [2:0] dst_sel,
  output reg  [2:0] src_sel,
  output reg  [1:0] pair_sel,
  output reg  [15:0] imm_value,
  output reg        copy_op,
  output reg        mem_store,
  output reg        mem_load,
  output reg        load_pair_immediate_op,
  output reg        stack_pointer_load,
  output reg        swap_stack_top_op,
  output reg        jump_via_hl_op,
  output reg        unsupported,
  // datapath handshake
  input  wire       exec_ready
);

  ////////////////////////////////////////////////////////////////////////////////
  localparam ST_OPC = 2'h0;
  localparam ST_LO  = 2'h1;
  localparam ST_HI  = 2'h2;
  localparam ST_OUT = 2'h3;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [7:0]  opc_reg;
  reg  [7:0]  lo_reg;
  wire [2:0]  cls_w;
  wire [1:0]  pair_w;
  wire        imm_w;
  wire        take;
  wire [7:0]  cur_opc;

  // classify either the new byte or the held opcode
  assign cur_opc = (state_reg == ST_OPC) ? fetch_byte : opc_reg;

  cpudec_cls u_cls (
    .opcode   (cur_opc),
    .op_class (cls_w),
    .pair_sel (pair_w),
    .two_imm  (imm_w)
  );

  // hold the fetch while a decoded result waits for the datapath
  assign fetch_ready = (state_reg != ST_OUT);
  assign take        = fetch_valid & fetch_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer: opcode, then low and high immediate bytes for 16-bit loads
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OPC:  if (take) state_next = imm_w ? ST_LO : ST_OUT;
      ST_LO:   if (take) state_next = ST_HI;
      ST_HI:   if (take) state_next = ST_OUT;
      ST_OUT:  if (exec_ready) state_next = ST_OPC;
      default: state_next = ST_OPC;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_OPC;
      opc_reg   <= 8'h00;
      lo_reg    <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (take && state_reg == ST_OPC) opc_reg <= fetch_byte;
      if (take && state_reg == ST_LO)  lo_reg  <= fetch_byte; // low byte comes first
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // result registers: loaded once the instruction is complete, held until taken
  always @(posedge clk) begin
    if (srst) begin
      dec_valid              <= 1'b0;
      op_class               <= `CPUDEC_RST_CLASS;
      dst_sel                <= `CPUDEC_RST_SEL;
      src_sel                <= `CPUDEC_RST_SEL;
      pair_sel               <= `CPUDEC_PAIR_BC;
      imm_value              <= 16'h0000;
      copy_op                <= 1'b0;
      mem_store              <= 1'b0;
      mem_load               <= 1'b0;
      load_pair_immediate_op <= 1'b0;
      stack_pointer_load     <= 1'b0;
      swap_stack_top_op      <= 1'b0;
      jump_via_hl_op         <= 1'b0;
      unsupported            <= 1'b0;
    end else if (state_reg == ST_OUT) begin
      if (exec_ready) dec_valid <= 1'b0;
    end else if (take && (state_reg == ST_HI || (state_reg == ST_OPC && !imm_w))) begin
      dec_valid              <= 1'b1;
      op_class               <= cls_w;
      dst_sel                <= cur_opc[`CPUDEC_DST_MSB:`CPUDEC_DST_LSB];
      src_sel                <= cur_opc[`CPUDEC_SRC_MSB:`CPUDEC_SRC_LSB];
      pair_sel               <= pair_w;
      imm_value              <= (state_reg == ST_HI) ? {fetch_byte, lo_reg} : 16'h0000;
      copy_op                <= (cls_w == `CPUDEC_CLS_COPY);
      mem_store              <= (cls_w == `CPUDEC_CLS_STORE);
      mem_load               <= (cls_w == `CPUDEC_CLS_LOAD);
      load_pair_immediate_op <= (cls_w == `CPUDEC_CLS_LDPAIR);
      stack_pointer_load     <= (cls_w == `CPUDEC_CLS_LDSP);
      swap_stack_top_op      <= (cls_w == `CPUDEC_CLS_SWAP);
      jump_via_hl_op         <= (cls_w == `CPUDEC_CLS_JHL);
      unsupported            <= (cls_w == `CPUDEC_CLS_NONE);
    end
  end

endmodule

/* verif/cpudec_checker.sv */
`timescale 1ns/1ns
// watches the decoder ports only; fields are checked whenever a class flag other than unsupported is up
module cpudec_checker (
  input wire        clk, srst, fetch_valid, fetch_ready, exec_ready, dec_valid,
  input wire [2:0]  op_class, dst_sel, src_sel,
  input wire [1:0]  pair_sel,
  input wire [15:0] imm_value,
  input wire        copy_op, mem_store, mem_load, load_pair_immediate_op,
  input wire        stack_pointer_load, swap_stack_top_op, jump_via_hl_op, unsupported
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // class flags must agree with class code, operand fields and pair select
  chk_copy_fields: assert property (copy_op |-> op_class == 3'h1
    && dst_sel != 3'h6 && src_sel != 3'h6) else $error("copy fields wrong");
  chk_store_hl: assert property (mem_store |-> op_class == 3'h2 && dst_sel == 3'h6
    && src_sel != 3'h6 && pair_sel == 2'h2) else $error("store fields wrong");
  chk_load_hl: assert property (mem_load |-> op_class == 3'h3 && src_sel == 3'h6
    && dst_sel != 3'h6 && pair_sel == 2'h2) else $error("load fields wrong");
  chk_pair_imm: assert property (load_pair_immediate_op |-> op_class == 3'h4
    && pair_sel != 2'h3) else $error("pair load wrong");
  chk_sp_imm: assert property (stack_pointer_load |-> op_class == 3'h5
    && pair_sel == 2'h3) else $error("stack pointer load wrong");
  chk_swap_hl: assert property (swap_stack_top_op |-> op_class == 3'h6
    && pair_sel == 2'h2 && imm_value == 16'h0) else $error("swap wrong");
  chk_jump_hl: assert property (jump_via_hl_op |-> op_class == 3'h7
    && pair_sel == 2'h2) else $error("jump via pair wrong");
  // a stalled result must not move and must refuse new bytes
  chk_hold_result: assert property (dec_valid && !exec_ready |=> dec_valid && !fetch_ready
    && $stable(op_class) && $stable(imm_value)) else $error("result moved in stall");
  chk_drop_valid: assert property (dec_valid && exec_ready |=> !dec_valid && fetch_ready)
    else $error("result not released");
  chk_one_hot: assert property (dec_valid |-> $onehot({copy_op, mem_store, mem_load,
    load_pair_immediate_op, stack_pointer_load, swap_stack_top_op, jump_via_hl_op,
    unsupported})) else $error("class flags not one hot");
endmodule
bind cpudec_top cpudec_checker i_cpudec_checker (.*);

/* verif/cpudec_fetch_model.sv */
`timescale 1ns/1ns
// fetch side: sends count bytes of bytes, low byte first; slow adds a one-cycle gap between bytes
module cpudec_fetch_model (
  input  wire        clk, srst, go, slow, fetch_ready,
  input  wire [23:0] bytes,
  input  wire [1:0]  count,
  output reg  [7:0]  fetch_byte,
  output reg         fetch_valid,
  output reg         busy
);
  reg [1:0] idx_reg;
  // byte held until taken; idle data inverts each cycle so stale values never match
  always @(posedge clk) begin
    if (srst) begin
      fetch_valid <= 1'b0;
      busy        <= 1'b0;
      fetch_byte  <= 8'h00;
      idx_reg     <= 2'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      fetch_valid <= 1'b1;
      fetch_byte <= bytes[7:0];
      idx_reg <= 2'h0;
    end else if (fetch_valid && fetch_ready) begin
      idx_reg <= idx_reg + 2'h1;
      fetch_valid <= !slow && (idx_reg + 2'h1 != count);
      fetch_byte <= (slow || idx_reg + 2'h1 == count) ? ~fetch_byte : bytes[8*(idx_reg+1)+:8];
      busy <= (idx_reg + 2'h1 != count);
    end else if (busy && !fetch_valid) begin
      fetch_valid <= 1'b1;
      fetch_byte <= bytes[8*idx_reg+:8];
    end else if (!fetch_valid)
      fetch_byte <= ~fetch_byte;
  end
endmodule

/* verif/cpudec_top_tb.sv */
`timescale 1ns/1ns
module cpudec_top_tb;
  typedef struct packed {logic [23:0] b; logic [1:0] n; logic [2:0] c;
    logic [1:0] p;} cpudec_row_t;
  reg clk, srst, exec_ready, go, slow;
  reg [23:0] bytes;
  reg [1:0] count;
  wire [7:0] fetch_byte;
  wire [2:0] op_class, dst_sel, src_sel;
  wire [1:0] pair_sel;
  wire [15:0] imm_value;
  wire [7:0] flags;
  wire fetch_valid, fetch_ready, busy, dec_valid;
  int bad_count, tests_run, i, k;
  cpudec_row_t rows [0:13];
  cpudec_fetch_model i_cpudec_fetch_model (.clk(clk), .srst(srst), .go(go), .slow(slow),
    .fetch_ready(fetch_ready), .bytes(bytes), .count(count), .fetch_byte(fetch_byte),
    .fetch_valid(fetch_valid), .busy(busy));
  cpudec_top i_cpudec_top (.clk(clk), .srst(srst), .fetch_byte(fetch_byte),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .dec_valid(dec_valid),
    .op_class(op_class), .dst_sel(dst_sel), .src_sel(src_sel), .pair_sel(pair_sel),
    .imm_value(imm_value), .copy_op(flags[1]), .mem_store(flags[2]), .mem_load(flags[3]),
    .load_pair_immediate_op(flags[4]), .stack_pointer_load(flags[5]),
    .swap_stack_top_op(flags[6]), .jump_via_hl_op(flags[7]), .unsupported(flags[0]),
    .exec_ready(exec_ready));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task fail(input string m);
    bad_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  // bounded wait so a dead handshake ends the run instead of hanging it
  task wait_dec;
    for (k = 0; k < 20 && dec_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (dec_valid !== 1'b1) begin
      fail("no decode");
      close_out;
    end
  endtask
  task send(input cpudec_row_t r, input logic s);
    @(posedge clk);
    #1 {bytes, count, slow, go} = {r.b, r.n, s, 1'b1};
    @(posedge clk);
    #1 go = 1'b0;
  endtask
  // flags are one-hot by class code, unsupported sits at bit 0
  task check_row(input cpudec_row_t r);
    tests_run++;
    if (op_class !== r.c) fail("class");
    if (flags !== 8'h01 << r.c) fail("flags");
    if (r.c inside {3'h1, 3'h2, 3'h3} && {dst_sel, src_sel} !== r.b[5:0]) fail("fields");
    if (pair_sel !== r.p) fail("pair");
    if (imm_value !== (r.n == 2'h3 ? r.b[23:8] : 16'h0)) fail("immediate");
  endtask
  initial begin
    {exec_ready, go, slow, bytes, count, bad_count, tests_run} = 0;
    rows = '{'{24'h78, 1, 1, 0}, '{24'h4d, 1, 1, 0}, '{24'h77, 1, 2, 2}, '{24'h70, 1, 2, 2},
      '{24'h7e, 1, 3, 2}, '{24'h46, 1, 3, 2}, '{24'h123401, 3, 4, 0}, '{24'hbeef11, 3, 4, 1},
      '{24'h000121, 3, 4, 2}, '{24'hffff31, 3, 5, 3}, '{24'he3, 1, 6, 2}, '{24'he9, 1, 7, 2},
      '{24'h76, 1, 0, 0}, '{24'heb, 1, 0, 0}};
    srst = 1'b1;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    exec_ready = 1'b1;
    tests_run++;
    if (dec_valid !== 1'b0 || fetch_ready !== 1'b1) fail("reset state");
    for (i = 0; i < 14; i++) begin
      send(rows[i], i[0]);
      wait_dec;
      check_row(rows[i]);
    end
    // stall: a waiting pair load must be refused until the swap result is taken
    // the last row is released first, else the stale result would block the swap
    @(posedge clk);
    #1 exec_ready = 1'b0;
    send(rows[10], 1'b0);
    wait_dec;
    send(rows[8], 1'b1);
    repeat (4) @(posedge clk);
    #1;
    tests_run++;
    if (op_class !== 3'h6 || fetch_ready !== 1'b0 || fetch_valid !== 1'b1) fail("stall");
    exec_ready = 1'b1;
    @(posedge clk);
    #1 wait_dec;
    check_row(rows[8]);
    // reset in mid-sequence drops the partial load and leaves no stale bytes
    send(rows[9], 1'b1);
    // opcode and low byte are taken by now, so the reset cuts a partial load
    repeat (3) @(posedge clk);
    #1 srst = 1'b1;
    @(posedge clk);
    #1 srst = 1'b0;
    tests_run++;
    if (dec_valid !== 1'b0 || fetch_ready !== 1'b1) fail("mid reset");
    send(rows[0], 1'b0);
    wait_dec;
    check_row(rows[0]);
    close_out;
  end
endmodule
